/* File: hw/page_request_pkg.sv */
package page_request_pkg;
	// register byte offsets on the axi4-lite bus
	localparam logic [7:0] HEADER_OFFSET      = 8'h00;
	localparam logic [7:0] CONTROL_OFFSET     = 8'h04;
	localparam logic [7:0] STATUS_OFFSET      = 8'h08;
	localparam logic [7:0] IRQ_STATUS_OFFSET  = 8'h0c;
	localparam logic [7:0] IRQ_ENABLE_OFFSET  = 8'h10;
	localparam logic [7:0] IRQ_CLEAR_OFFSET   = 8'h14;
	localparam int         ADDR_WIDTH         = 8;

	// capability header fields
	localparam int         NEXT_PTR_LSB       = 20;
	localparam int         VERSION_LSB        = 16;
	localparam int         CAP_ID_LSB         = 0;
	localparam logic [3:0] CAP_VERSION        = 4'h1;
	localparam logic [15:0] CAP_ID            = 16'h0013;
	localparam logic [11:0] NEXT_PTR_RESET    = 12'h000;

	// control fields
	localparam int         CTRL_ENABLE_BIT    = 0;
	localparam int         CTRL_RESET_BIT     = 1;
	localparam logic       ENABLE_RESET       = 1'b0;

	// status fields
	localparam int         STAT_FAIL_BIT      = 0;
	localparam int         STAT_UNEXP_BIT     = 1;
	localparam int         STAT_STOPPED_BIT   = 8;
	localparam logic       STOPPED_RESET      = 1'b0;

	// response failure code carried by a response
	localparam logic [3:0] RESP_CODE_FAILURE  = 4'hf;

	// interrupt status layout
	localparam int         IRQ_UNEXP_BIT      = 0;
	localparam int         IRQ_FAIL_BIT       = 1;
	localparam int         IRQ_STOPPED_BIT    = 2;
	localparam int         IRQ_COUNT          = 3;

	localparam logic [1:0] RESP_OKAY          = 2'b00;
	localparam logic [1:0] RESP_SLVERR        = 2'b10;
endpackage : page_request_pkg

/* File: hw/page_request_regs.sv */
`timescale 1ns/10ps
// Contract
// - the header's top twelve bits hold a read-only pointer to the next capability.
// - the header's version field reads as one and cannot be written.
// - the low sixteen header bits read as the fixed page request capability identifier.
// - the interface-reset control bit always reads zero and ignores writes.
// - writing the reset bit with zero, or with anything while enabled, starts nothing.
// - the enable bit is read-write, zero after reset, and allows page requests when set.
// - with enable and stopped both clear, no new page requests may be issued.
// - a rising edge of the enable bit clears every status field unless a response sets fail or unexpected in that cycle.
// - the enable bit steers stopped and the issue permission, and reads back in the control register.
// - stopped sets when enable falls and clears when enable rises.
// - a group response with an unmatched index is ignored and sets a write-one-clear flag; the code handles an unmatched failure response as a failure only.
// - a failure response sets a write-one-clear flag and terminates its context with error.
module page_request_regs #(
	parameter logic [11:0] NEXT_PTR = page_request_pkg::NEXT_PTR_RESET
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// page response events from the translation logic
	input  wire logic        resp_valid,
	input  wire logic        resp_index_match,
	input  wire logic [3:0]  resp_code,
	// page request side
	input  wire logic        req_pending,
	output logic             req_issue_allowed,
	output logic             context_fail,
	output logic             irq
);
	logic        aw_held_reg;
	logic [7:0]  aw_addr_reg;
	logic        w_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        enable_reg;
	logic        stopped_reg;
	logic        stopped_next;
	logic        req_ok_reg;
	logic        fail_out_reg;
	logic        irq_reg;
	logic [page_request_pkg::IRQ_COUNT-1:0] irq_en_reg;
	logic [page_request_pkg::IRQ_COUNT-1:0] irq_stat;
	logic        unexp_flag;
	logic        fail_flag;
	logic        wr_go;
	logic        wr_ctrl;
	logic        enable_next;
	logic        enable_rise;
	logic        enable_fall;
	logic        resp_fail;
	logic        resp_unexp;
	logic        clr_unexp;
	logic        clr_fail;
	logic [page_request_pkg::IRQ_COUNT-1:0] irq_clr;
	logic [page_request_pkg::IRQ_COUNT-1:0] irq_set;
	logic [31:0] header_val;
	logic [31:0] control_val;
	logic [31:0] status_val;
	logic [31:0] rd_val;
	logic        rd_hit;
	logic        wr_hit;
	logic        wr_status;

	// write address and data may arrive in either order; each is held until both exist
	assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg   <= 1'b0;
			aw_addr_reg   <= 8'h00;
			s_axi_awready <= 1'b0;
		end else if (ce) begin
			s_axi_awready <= 1'b0;
			if (wr_go) begin
				aw_held_reg <= 1'b0;
			end else if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (!aw_held_reg && s_axi_awvalid) begin
				s_axi_awready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_reg   <= 1'b0;
			w_data_reg   <= 32'h0000_0000;
			w_strb_reg   <= 4'h0;
			s_axi_wready <= 1'b0;
		end else if (ce) begin
			s_axi_wready <= 1'b0;
			if (wr_go) begin
				w_held_reg <= 1'b0;
			end else if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (!w_held_reg && s_axi_wvalid) begin
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_comb begin
		unique case (aw_addr_reg)
			page_request_pkg::HEADER_OFFSET,
			page_request_pkg::CONTROL_OFFSET,
			page_request_pkg::STATUS_OFFSET,
			page_request_pkg::IRQ_STATUS_OFFSET,
			page_request_pkg::IRQ_ENABLE_OFFSET,
			page_request_pkg::IRQ_CLEAR_OFFSET: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= page_request_pkg::RESP_OKAY;
		end else if (ce) begin
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? page_request_pkg::RESP_OKAY
				                       : page_request_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// control register: only byte lane 0 holds live bits
	assign wr_ctrl = wr_go && (aw_addr_reg == page_request_pkg::CONTROL_OFFSET) && w_strb_reg[0];
	// the reset bit is never stored and triggers no clearing of any state
	assign enable_next = wr_ctrl ? w_data_reg[page_request_pkg::CTRL_ENABLE_BIT] : enable_reg;
	assign enable_rise = enable_next && !enable_reg;
	assign enable_fall = !enable_next && enable_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable_reg <= page_request_pkg::ENABLE_RESET;
		end else if (ce) begin
			enable_reg <= enable_next;
		end
	end

	// stopped follows the enable edges only
	always_comb begin
		stopped_next = stopped_reg;
		if (enable_rise) begin
			stopped_next = 1'b0;
		end else if (enable_fall) begin
			stopped_next = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stopped_reg <= page_request_pkg::STOPPED_RESET;
		end else if (ce) begin
			stopped_reg <= stopped_next;
		end
	end

	// new requests only while enabled, or once stopped; the next stopped value
	// keeps permission from dipping for one cycle as enable falls
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_ok_reg <= 1'b0;
		end else if (ce) begin
			req_ok_reg <= enable_next || stopped_next;
		end
	end
	assign req_issue_allowed = req_ok_reg;

	// responses are ignored apart from setting flags and, on the failure code, pulsing context_fail
	assign resp_fail  = resp_valid && (resp_code == page_request_pkg::RESP_CODE_FAILURE);
	assign resp_unexp = resp_valid && !resp_index_match && !resp_fail;

	// write-one-clear on status, lane 0 only; an enable rise clears both flags, but a response in the same cycle sets its flag
	assign wr_status = wr_go && (aw_addr_reg == page_request_pkg::STATUS_OFFSET) && w_strb_reg[0];
	assign clr_unexp = enable_rise
		|| (wr_status && w_data_reg[page_request_pkg::STAT_UNEXP_BIT]);
	assign clr_fail  = enable_rise
		|| (wr_status && w_data_reg[page_request_pkg::STAT_FAIL_BIT]);

	sticky_flag unexp_inst (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.set     (resp_unexp),
		.clr     (clr_unexp),
		.flag    (unexp_flag)
	);

	sticky_flag fail_inst (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.set     (resp_fail),
		.clr     (clr_fail),
		.flag    (fail_flag)
	);

	// failing response terminates the matching context
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fail_out_reg <= 1'b0;
		end else if (ce) begin
			fail_out_reg <= resp_fail;
		end
	end
	assign context_fail = fail_out_reg;

	// interrupt status: separate sticky copies of each event
	assign irq_set[page_request_pkg::IRQ_UNEXP_BIT]   = resp_unexp;
	assign irq_set[page_request_pkg::IRQ_FAIL_BIT]    = resp_fail;
	assign irq_set[page_request_pkg::IRQ_STOPPED_BIT] = enable_fall;
	assign irq_clr = (wr_go && (aw_addr_reg == page_request_pkg::IRQ_CLEAR_OFFSET) && w_strb_reg[0])
		? w_data_reg[page_request_pkg::IRQ_COUNT-1:0] : '0;

	genvar gi;
	generate
		for (gi = 0; gi < page_request_pkg::IRQ_COUNT; gi++) begin : g_irq
			sticky_flag irq_flag_inst (
				.aclk    (aclk),
				.aresetn (aresetn),
				.ce      (ce),
				.set     (irq_set[gi]),
				.clr     (irq_clr[gi]),
				.flag    (irq_stat[gi])
			);
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_en_reg <= '0;
		end else if (ce) begin
			if (wr_go && (aw_addr_reg == page_request_pkg::IRQ_ENABLE_OFFSET) && w_strb_reg[0]) begin
				irq_en_reg <= w_data_reg[page_request_pkg::IRQ_COUNT-1:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_reg <= 1'b0;
		end else if (ce) begin
			irq_reg <= |(irq_stat & irq_en_reg);
		end
	end
	assign irq = irq_reg;

	// read values
	always_comb begin
		header_val = 32'h0000_0000;
		header_val[31:page_request_pkg::NEXT_PTR_LSB] = NEXT_PTR;
		header_val[page_request_pkg::VERSION_LSB +: 4] = page_request_pkg::CAP_VERSION;
		header_val[page_request_pkg::CAP_ID_LSB +: 16] = page_request_pkg::CAP_ID;
	end

	always_comb begin
		control_val = 32'h0000_0000;
		control_val[page_request_pkg::CTRL_ENABLE_BIT] = enable_reg;
	end

	always_comb begin
		status_val = 32'h0000_0000;
		status_val[page_request_pkg::STAT_FAIL_BIT]    = fail_flag;
		status_val[page_request_pkg::STAT_UNEXP_BIT]   = unexp_flag;
		status_val[page_request_pkg::STAT_STOPPED_BIT] = stopped_reg;
	end

	always_comb begin
		rd_hit = 1'b1;
		rd_val = 32'h0000_0000;
		unique case (s_axi_araddr)
			page_request_pkg::HEADER_OFFSET:     rd_val = header_val;
			page_request_pkg::CONTROL_OFFSET:    rd_val = control_val;
			page_request_pkg::STATUS_OFFSET:     rd_val = status_val;
			page_request_pkg::IRQ_STATUS_OFFSET: rd_val = {29'h0, irq_stat};
			page_request_pkg::IRQ_ENABLE_OFFSET: rd_val = {29'h0, irq_en_reg};
			page_request_pkg::IRQ_CLEAR_OFFSET:  rd_val = 32'h0000_0000;
			default:                             rd_hit = 1'b0;
		endcase
	end

	// read: arready pulses for one cycle, data follow next edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= page_request_pkg::RESP_OKAY;
		end else if (ce) begin
			s_axi_arready <= 1'b0;
			if (s_axi_rvalid) begin
				if (s_axi_rready) begin
					s_axi_rvalid <= 1'b0;
				end
			end else if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_val;
				s_axi_rresp  <= rd_hit ? page_request_pkg::RESP_OKAY
				                       : page_request_pkg::RESP_SLVERR;
			end else if (s_axi_arvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// req_pending is informational; the device keeps no credit state to clear
	logic unused_pending;
	assign unused_pending = req_pending;
endmodule : page_request_regs

/* File: hw/sticky_flag.sv */
`timescale 1ns/10ps
// one sticky flag: set wins over clear
module sticky_flag (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic ce,
	input  wire logic set,
	input  wire logic clr,
	output logic      flag
);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag <= 1'b0;
		end else if (ce) begin
			if (set) begin
				flag <= 1'b1;
			end else if (clr) begin
				flag <= 1'b0;
			end
		end
	end
endmodule : sticky_flag

/* File: verification/page_request_properties.sv */
`timescale 1ns/10ps
module page_request_properties #(
	parameter logic [11:0] NEXT_PTR = page_request_pkg::NEXT_PTR_RESET
) (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        ce,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        resp_valid,
	input wire logic [3:0]  resp_code,
	input wire logic        req_issue_allowed,
	input wire logic        context_fail
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [7:0] rd_addr_reg;
	logic       fail_in;
	assign fail_in = ce && resp_valid && resp_code == page_request_pkg::RESP_CODE_FAILURE;
	// remembers which register the pending read answers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_addr_reg <= 8'h00;
		end else if (ce && s_axi_arvalid && s_axi_arready) begin
			rd_addr_reg <= s_axi_araddr;
		end
	end
	sequence s_fail_resp;
		fail_in;
	endsequence
	sequence s_read_of(logic [7:0] a);
		s_axi_rvalid && rd_addr_reg == a;
	endsequence
	a_header_read: assert property (s_read_of(page_request_pkg::HEADER_OFFSET) |->
		s_axi_rdata == {NEXT_PTR, page_request_pkg::CAP_VERSION, page_request_pkg::CAP_ID})
		else $error("header read value wrong");
	a_ctrl_reserved: assert property (s_read_of(page_request_pkg::CONTROL_OFFSET) |->
		s_axi_rdata[31:1] == 31'h0) else $error("control upper bits not zero");
	a_status_reserved: assert property (s_read_of(page_request_pkg::STATUS_OFFSET) |->
		{s_axi_rdata[31:9], s_axi_rdata[7:2]} == 29'h0) else $error("status reserved bits set");
	a_fail_pulse: assert property (s_fail_resp |-> ##[1:2] context_fail)
		else $error("no context failure after failure response");
	a_fail_cause: assert property (context_fail |-> $past(fail_in) || $past(fail_in, 2))
		else $error("context failure without cause");
	a_allowed_sticky: assert property ($past(req_issue_allowed) |-> req_issue_allowed)
		else $error("issue permission dropped");
	a_bvalid_hold: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
		else $error("write response withdrawn");
	a_rvalid_hold: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
		else $error("read data withdrawn");
	a_rdata_stable: assert property (!(ce && s_axi_arvalid && s_axi_arready) |=>
		$stable(s_axi_rdata)) else $error("read data changed without a read");
endmodule : page_request_properties

bind page_request_regs page_request_properties #(.NEXT_PTR(NEXT_PTR)) u_page_request_properties (
	.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.resp_valid(resp_valid), .resp_code(resp_code), .req_issue_allowed(req_issue_allowed),
	.context_fail(context_fail));

/* File: verification/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	localparam logic [11:0] NP  = 12'h1a4;
	localparam logic [7:0]  HDR = page_request_pkg::HEADER_OFFSET;
	localparam logic [7:0]  CTL = page_request_pkg::CONTROL_OFFSET;
	localparam logic [7:0]  STA = page_request_pkg::STATUS_OFFSET;
	localparam logic [7:0]  IST = page_request_pkg::IRQ_STATUS_OFFSET;
	localparam logic [7:0]  IEN = page_request_pkg::IRQ_ENABLE_OFFSET;
	localparam logic [7:0]  ICL = page_request_pkg::IRQ_CLEAR_OFFSET;
	logic        aclk = 1'b0;
	logic        aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, resp_valid, resp_index_match;
	logic        req_pending, req_issue_allowed, context_fail, irq, ce;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, v, d;
	logic [3:0]  wstrb, resp_code;
	logic [1:0]  bresp, rresp, r;
	int          errors, n_tests, seed, ef, i;
	int          fails = 0;

	page_request_regs #(.NEXT_PTR(NP)) u_page_request_regs (
		.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.resp_valid(resp_valid), .resp_index_match(resp_index_match), .resp_code(resp_code),
		.req_pending(req_pending), .req_issue_allowed(req_issue_allowed),
		.context_fail(context_fail), .irq(irq));

	initial begin
		forever #4 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		if (context_fail === 1'b1) fails++;
	end

	function automatic logic [31:0] st(input logic f, input logic u, input logic s);
		return {23'h0, s, 6'h0, u, f};
	endfunction : st

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			errors++;
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] dv);
		@(posedge aclk);
		awaddr <= a;
		wdata <= dv;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int k = 0; k < 40; k++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				return;
			end
		end
		errors++;
		complete_run();
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int k = 0; k < 40; k++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				v = rdata;
				r = rresp;
				rready <= 1'b0;
				return;
			end
		end
		errors++;
		complete_run();
	endtask : rd

	task automatic ev(input logic [3:0] c, input logic m);
		@(posedge aclk);
		resp_valid <= 1'b1;
		resp_code <= c;
		resp_index_match <= m;
		@(posedge aclk);
		resp_valid <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask : ev

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, resp_valid} = 7'h00;
		{resp_index_match, req_pending, resp_code, awaddr, araddr} = 22'h0;
		wdata = 32'h0;
		wstrb = 4'hf;
		ce = 1'b1;
		seed = 70;
		errors = 0;
		n_tests = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(HDR); chk(v, {NP, page_request_pkg::CAP_VERSION, page_request_pkg::CAP_ID});
		wr(HDR, 32'hffffffff);
		rd(HDR); chk(v, {NP, page_request_pkg::CAP_VERSION, page_request_pkg::CAP_ID});
		$display("header test done");
		rd(CTL); chk(v, 32'h0);
		chk(32'(req_issue_allowed), 32'h0);
		wr(CTL, 32'hffffffff);
		rd(CTL); chk(v, 32'h1);
		chk(32'(req_issue_allowed), 32'h1);
		wr(CTL, 32'h2);
		rd(CTL); chk(v, 32'h0);
		rd(STA); chk(v, st(1'b0, 1'b0, 1'b1));
		chk(32'(req_issue_allowed), 32'h1);
		$display("control test done");
		wr(IEN, 32'h7);
		repeat (2) @(posedge aclk);
		chk(32'(irq), 32'h1);
		wr(ICL, 32'h7);
		repeat (2) @(posedge aclk);
		chk(32'(irq), 32'h0);
		rd(ICL); chk(v, 32'h0);
		ev(4'hf, 1'b1); chk(fails, 1);
		rd(STA); chk(v, st(1'b1, 1'b0, 1'b1));
		chk(32'(irq), 32'h1);
		ev(4'h0, 1'b0); chk(fails, 1);
		rd(STA); chk(v, st(1'b1, 1'b1, 1'b1));
		rd(IST); chk(v, 32'h3);
		wr(STA, 32'h1);
		rd(STA); chk(v, st(1'b0, 1'b1, 1'b1));
		wr(IEN, 32'h0);
		wr(ICL, 32'h7);
		ev(4'hf, 1'b0); chk(32'(irq), 32'h0);
		rd(IST); chk(v, 32'h2);
		wr(CTL, 32'h1);
		rd(STA); chk(v, st(1'b0, 1'b0, 1'b0));
		$display("event test done");
		ce <= 1'b0;
		ev(4'hf, 1'b0); chk(fails, 2);
		ce <= 1'b1;
		rd(STA); chk(v, st(1'b0, 1'b0, 1'b0));
		$display("freeze test done");
		wr(8'h20, 32'h1); chk(32'(r), 32'(page_request_pkg::RESP_SLVERR));
		rd(8'h20); chk(32'(r), 32'(page_request_pkg::RESP_SLVERR));
		chk(v, 32'h0);
		$display("unmapped test done");
		ef = 2;
		for (i = 0; i < 16; i++) begin
			d = $random(seed);
			wr(CTL, d);
			rd(CTL); chk(v, {31'h0, d[0]});
			ev(d[7:4] | {4{d[8]}}, d[9]);
			if ((d[7:4] | {4{d[8]}}) == 4'hf) ef++;
			chk(fails, ef);
		end
		$display("random test done");
		complete_run();
	end
endmodule : tb_top
